// file: hdl/aux_cal_pkg.sv
// Package with register map, field layout, reset values and types for the auxiliary ADC calibration stage.
package aux_cal_pkg;

	// Widths of the conversion result and of the coefficient field.
	localparam int RESULT_W = 16;
	localparam int COEF_W = 15;
	localparam int AXI_ADDR_W = 14;
	localparam int AXI_DATA_W = 32;

	// Byte addresses of the registers.
	localparam logic [AXI_ADDR_W-1:0] ADDR_GAIN_COEF_PGA1P5 = 14'h2270;
	localparam logic [AXI_ADDR_W-1:0] ADDR_OFFSET_COEF_PGA2 = 14'h22C8;
	localparam logic [AXI_ADDR_W-1:0] ADDR_OFFSET_COEF_PGA1P5 = 14'h22CC;
	localparam logic [AXI_ADDR_W-1:0] ADDR_CAL_STATUS = 14'h2300;

	// Coefficient field position and reset values.
	localparam int COEF_MSB = 14;
	localparam int COEF_LSB = 0;
	localparam logic [COEF_W-1:0] GAIN_COEF_RESET = 15'h4000;
	localparam logic [COEF_W-1:0] OFFSET_COEF_RESET = 15'h0000;
	localparam logic [COEF_W-1:0] GAIN_COEF_UNITY = 15'h4000;
	localparam logic [COEF_W-1:0] GAIN_COEF_ILLEGAL = 15'h0000;

	// Fixed-point layout: offsets in quarter LSBs, gain with 14 fraction bits.
	localparam int OFFSET_FRAC_BITS = 2;
	localparam int GAIN_FRAC_BITS = 14;
	localparam int CORR_W = RESULT_W + OFFSET_FRAC_BITS + 2;
	localparam int PROD_W = CORR_W + COEF_W + 1;
	localparam int PROD_SHIFT = OFFSET_FRAC_BITS + GAIN_FRAC_BITS;

	// Status register field positions.
	localparam int STAT_RESULT_LSB = 0;
	localparam int STAT_SAT_BIT = 16;

	// AXI response codes.
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Gain setting of the programmable_gain_amp that the result was taken with.
	typedef enum logic [2:0] {
		PGA_GAIN_1 = 3'h0,
		PGA_GAIN_1P5 = 3'h1,
		PGA_GAIN_2 = 3'h3,
		PGA_GAIN_4 = 3'h2,
		PGA_GAIN_9 = 3'h6
	} pga_gain_e;

	// One conversion_result with its qualifiers.
	typedef struct packed {
		logic valid;
		pga_gain_e gain;
		logic excluded;
		logic [RESULT_W-1:0] result;
	} raw_sample_s;

	// One corrected result.
	typedef struct packed {
		logic valid;
		logic saturated;
		logic [RESULT_W-1:0] result;
	} cal_sample_s;

	// Coefficient set handed from the register file to the datapath.
	typedef struct packed {
		logic [COEF_W-1:0] gain_pga1p5;
		logic [COEF_W-1:0] offset_pga2;
		logic [COEF_W-1:0] offset_pga1p5;
	} coef_set_s;

endpackage

// file: hdl/cal_coef_reg.sv
// One writable 15-bit coefficient register with byte-lane enables.
`timescale 1ns/100ps
module cal_coef_reg #(
	parameter logic [14:0] RESET_VALUE = 15'h0000
) (
	input wire logic i_clk_sys,
	input wire logic i_nrst,
	input wire logic i_wr_en,
	input wire logic [1:0] i_wstrb,
	input wire logic [14:0] i_wdata,
	output logic [14:0] o_value
);
	logic [14:0] value_q;
	logic [14:0] value_d;

	// Each byte lane updates only its own bits.
	assign value_d[7:0] = (i_wr_en && i_wstrb[0]) ? i_wdata[7:0] : value_q[7:0];
	assign value_d[14:8] = (i_wr_en && i_wstrb[1]) ? i_wdata[14:8] : value_q[14:8];
	assign o_value = value_q;

	// Register with its documented reset value.
	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			value_q <= RESET_VALUE;
		end else begin
			value_q <= value_d;
		end
	end
endmodule

// file: hdl/cal_datapath.sv
// Two-stage offset subtraction, gain multiply and saturation of the auxiliary result.
`timescale 1ns/100ps
module cal_datapath (
	input wire logic i_clk_sys,
	input wire logic i_nrst,
	input aux_cal_pkg::raw_sample_s i_sample,
	input aux_cal_pkg::coef_set_s i_coefs,
	output aux_cal_pkg::cal_sample_s o_sample
);
	import aux_cal_pkg::*;

	logic [COEF_W-1:0] offset_sel;
	logic [COEF_W-1:0] gain_sel;
	logic signed [CORR_W-1:0] raw_q4;
	logic signed [CORR_W-1:0] offset_ext;
	logic signed [CORR_W-1:0] corr_d;
	logic signed [CORR_W-1:0] corr_q;
	logic [COEF_W-1:0] gain_q;
	logic valid_q;
	logic signed [PROD_W-1:0] prod;
	logic signed [PROD_W-1:0] scaled;
	logic zero_gain;
	logic sat_hi;
	logic sat_lo;
	cal_sample_s out_d;
	cal_sample_s out_q;

	// Offset by gain setting; other gains get no offset from this stage.
	assign offset_sel = (i_sample.gain == PGA_GAIN_1P5) ? i_coefs.offset_pga1p5 :
		(i_sample.gain == PGA_GAIN_2) ? i_coefs.offset_pga2 : OFFSET_COEF_RESET;

	// Gain applies at 1.5 except on transimpedance_amp and temperature channels.
	assign gain_sel = (i_sample.gain == PGA_GAIN_1P5 && !i_sample.excluded) ?
		i_coefs.gain_pga1p5 : GAIN_COEF_UNITY;

	// Work in quarter LSBs; the offset is a signed 15-bit quarter-LSB count.
	assign raw_q4 = CORR_W'({2'b00, i_sample.result, 2'b00});
	assign offset_ext = CORR_W'(signed'(offset_sel));
	assign corr_d = raw_q4 - offset_ext;

	// Gain bit 14 weighs 1.0 and bits 13..0 the fraction, so 0x7FFF is just under 2.
	assign prod = corr_q * signed'({1'b0, gain_q});
	assign scaled = (prod + PROD_W'(1 <<< (PROD_SHIFT - 1))) >>> PROD_SHIFT;
	assign zero_gain = (gain_q == GAIN_COEF_ILLEGAL);
	assign sat_lo = scaled < 0;
	assign sat_hi = scaled > PROD_W'(2 ** RESULT_W - 1);

	// Clamp to the unsigned result range; an illegal zero gain forces zero.
	always_comb begin
		out_d.valid = valid_q;
		out_d.saturated = 1'b0;
		out_d.result = '0;
		if (zero_gain) begin
			out_d.result = '0;
		end else if (sat_lo) begin
			out_d.saturated = 1'b1;
		end else if (sat_hi) begin
			out_d.saturated = 1'b1;
			out_d.result = '1;
		end else begin
			out_d.result = scaled[RESULT_W-1:0];
		end
	end

	assign o_sample = out_q;

	// Pipeline registers for both stages.
	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			corr_q <= '0;
			gain_q <= GAIN_COEF_UNITY;
			valid_q <= 1'b0;
			out_q <= '0;
		end else begin
			corr_q <= corr_d;
			gain_q <= gain_sel;
			valid_q <= i_sample.valid;
			out_q <= out_d;
		end
	end
endmodule

// file: hdl/adc_aux_gain_offset_cal.sv
// Top of the auxiliary ADC calibration stage with its AXI4-Lite register slave.
//
// What this block does
// - Gain 1.5 uses its own offset coefficient.
// - Gain 2 uses its own offset coefficient.
// - Offset is signed 15 bits, quarter-LSB steps.
// - Offset 0 none, 1 plus, 7FFF minus quarter.
// - Offset spans +4095.75 down to -4096 LSB.
// - Gain 1.5 coefficient skips excluded channels.
// - Gain bit 14 integer, bits 13..0 fraction.
// - Gain 0x4000 is unity and reset value.
// - Gain 0x2000 halves the result.
// - Gain 0x7FFF near two, 0x4001 just above one.
// - Gain 0x3FFF below one, 0x0001 smallest.
// - Gain zero is illegal and yields zero.
// - Coefficient bits 31..15 read zero; offsets reset zero.
`timescale 1ns/100ps
module adc_aux_gain_offset_cal (
	input wire logic i_clk_sys,
	input wire logic i_nrst,
	// AXI4-Lite write address channel.
	input wire logic i_awvalid,
	input wire logic [aux_cal_pkg::AXI_ADDR_W-1:0] i_awaddr,
	input wire logic [2:0] i_awprot,
	output logic o_awready,
	// AXI4-Lite write data channel.
	input wire logic i_wvalid,
	input wire logic [aux_cal_pkg::AXI_DATA_W-1:0] i_wdata,
	input wire logic [3:0] i_wstrb,
	output logic o_wready,
	// AXI4-Lite write response channel.
	output logic o_bvalid,
	output logic [1:0] o_bresp,
	input wire logic i_bready,
	// AXI4-Lite read address channel.
	input wire logic i_arvalid,
	input wire logic [aux_cal_pkg::AXI_ADDR_W-1:0] i_araddr,
	input wire logic [2:0] i_arprot,
	output logic o_arready,
	// AXI4-Lite read data channel.
	output logic o_rvalid,
	output logic [aux_cal_pkg::AXI_DATA_W-1:0] o_rdata,
	output logic [1:0] o_rresp,
	input wire logic i_rready,
	// Raw conversion_result with the gain it was taken at.
	input wire logic i_raw_valid,
	input wire logic [aux_cal_pkg::RESULT_W-1:0] i_conversion_result,
	input aux_cal_pkg::pga_gain_e i_pga_gain,
	input wire logic i_excluded_channel,
	// Corrected result.
	output logic o_cal_valid,
	output logic [aux_cal_pkg::RESULT_W-1:0] o_cal_result,
	output logic o_cal_saturated
);
	import aux_cal_pkg::*;

	// The register slave answers in fixed steps. A write address and its data may arrive
	// in either order; each is parked in a holding register and its ready drops until the
	// pair has been applied. The write lands on the edge after the later of the two is taken,
	// and the response rises on that same edge. It stands until the master accepts it, and
	// no new write is applied while it stands, so a slow master cannot lose a response.
	// A read is answered on the edge that takes its address. The data are captured at that
	// edge and stand, with their response, until the master takes them. The read address
	// ready stays low while a read answer is pending, which limits the slave to one read
	// in flight and keeps the answer stable.
	// Unmapped or misaligned addresses are refused with an error response. A refused write
	// changes nothing; a refused read returns zero.
	// The protection bits of both address channels carry no meaning here and are ignored.

	// Write channel state.
	logic aw_full_q;
	logic aw_full_d;
	logic w_full_q;
	logic w_full_d;
	logic awready_q;
	logic wready_q;
	logic [AXI_ADDR_W-1:0] awaddr_q;
	logic [AXI_DATA_W-1:0] wdata_q;
	logic [3:0] wstrb_q;
	logic bvalid_q;
	logic bvalid_d;
	logic [1:0] bresp_q;
	logic [1:0] bresp_d;
	logic aw_take;
	logic w_take;
	logic wr_fire;

	// Read channel state.
	logic arready_q;
	logic rvalid_q;
	logic rvalid_d;
	logic [AXI_DATA_W-1:0] rdata_q;
	logic [AXI_DATA_W-1:0] rdata_d;
	logic [1:0] rresp_q;
	logic [1:0] rresp_d;
	logic ar_take;

	// Address decode.
	logic wr_sel_gain1p5;
	logic wr_sel_off2;
	logic wr_sel_off1p5;
	logic wr_hit;
	logic rd_sel_gain1p5;
	logic rd_sel_off2;
	logic rd_sel_off1p5;
	logic rd_sel_status;
	logic rd_hit;

	// Coefficients and datapath carriers.
	logic [COEF_W-1:0] gain_pga1p5;
	logic [COEF_W-1:0] offset_pga2;
	logic [COEF_W-1:0] offset_pga1p5;
	coef_set_s coefs;
	raw_sample_s raw_sample;
	cal_sample_s cal_sample;
	logic [RESULT_W-1:0] last_result_q;
	logic last_sat_q;

	// The readies come from flip-flops loaded from the next holding state, so each one matches the current holding state.
	// After reset they rise on the first edge, and the first request is taken on the second.
	// Handshake terms of the write and read address and data channels.
	assign aw_take = i_awvalid && awready_q;
	assign w_take = i_wvalid && wready_q;
	assign ar_take = i_arvalid && arready_q;

	// Gating the fire on a pending response keeps the response and its code from being
	// overwritten. The holding registers then simply wait, and their readies stay low,
	// which stalls the master rather than dropping its request.
	// A pending write blocks nothing on the read side.
	// A write proceeds once both address and data are held and no response is pending.
	assign wr_fire = aw_full_q && w_full_q && !bvalid_q;
	assign aw_full_d = (aw_full_q && !wr_fire) || aw_take;
	assign w_full_d = (w_full_q && !wr_fire) || w_take;
	assign bvalid_d = wr_fire || (bvalid_q && !i_bready);
	assign bresp_d = wr_fire ? (wr_hit ? RESP_OKAY : RESP_SLVERR) : bresp_q;

	// Write decode on the held address; only whole aligned words are mapped.
	assign wr_sel_gain1p5 = (awaddr_q == ADDR_GAIN_COEF_PGA1P5);
	assign wr_sel_off2 = (awaddr_q == ADDR_OFFSET_COEF_PGA2);
	assign wr_sel_off1p5 = (awaddr_q == ADDR_OFFSET_COEF_PGA1P5);
	assign wr_hit = wr_sel_gain1p5 || wr_sel_off2 || wr_sel_off1p5;

	// Read decode on the incoming address.
	assign rd_sel_gain1p5 = (i_araddr == ADDR_GAIN_COEF_PGA1P5);
	assign rd_sel_off2 = (i_araddr == ADDR_OFFSET_COEF_PGA2);
	assign rd_sel_off1p5 = (i_araddr == ADDR_OFFSET_COEF_PGA1P5);
	assign rd_sel_status = (i_araddr == ADDR_CAL_STATUS);
	assign rd_hit = rd_sel_gain1p5 || rd_sel_off2 || rd_sel_off1p5 || rd_sel_status;

	// The mux is only consulted on the taking edge; otherwise the held data recirculate.
	// This keeps the answer stable for a master that holds off its ready.
	// Read data mux; reserved bits above the coefficient field read as zero.
	assign rdata_d = !ar_take ? rdata_q :
		rd_sel_gain1p5 ? AXI_DATA_W'(gain_pga1p5) :
		rd_sel_off2 ? AXI_DATA_W'(offset_pga2) :
		rd_sel_off1p5 ? AXI_DATA_W'(offset_pga1p5) :
		rd_sel_status ? AXI_DATA_W'({last_sat_q, last_result_q}) : '0;
	assign rresp_d = !ar_take ? rresp_q : (rd_hit ? RESP_OKAY : RESP_SLVERR);
	assign rvalid_d = ar_take || (rvalid_q && !i_rready);

	// Write address and data holding registers.
	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			aw_full_q <= 1'b0;
			w_full_q <= 1'b0;
			awready_q <= 1'b0;
			wready_q <= 1'b0;
			awaddr_q <= '0;
			wdata_q <= '0;
			wstrb_q <= '0;
		end else begin
			aw_full_q <= aw_full_d;
			w_full_q <= w_full_d;
			awready_q <= !aw_full_d;
			wready_q <= !w_full_d;
			if (aw_take) begin
				awaddr_q <= i_awaddr;
			end
			if (w_take) begin
				wdata_q <= i_wdata;
				wstrb_q <= i_wstrb;
			end
		end
	end

	// Write response and read channel registers.
	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
			arready_q <= 1'b0;
			rvalid_q <= 1'b0;
			rdata_q <= '0;
			rresp_q <= RESP_OKAY;
		end else begin
			bvalid_q <= bvalid_d;
			bresp_q <= bresp_d;
			arready_q <= !rvalid_d;
			rvalid_q <= rvalid_d;
			rdata_q <= rdata_d;
			rresp_q <= rresp_d;
		end
	end

	// Each coefficient register keeps only the 15-bit field; the upper bits of a write are
	// dropped, so they always read back as zero. Only the two low byte strobes matter, one
	// for each byte of the field, which lets software update a single byte in place.
	// The upper strobes are ignored because nothing is stored under them.
	// A new coefficient reaches the datapath on the edge after the write lands. A sample
	// already inside the pipeline keeps the coefficients that it was taken with, because
	// the selected gain is registered alongside the first stage.
	// Software should write the gain before the offsets only if it can tolerate a few
	// samples corrected with one new and one old coefficient.

	// Gain coefficient for gain 1.5, unity after reset.
	cal_coef_reg #(
		.RESET_VALUE(GAIN_COEF_RESET)
	) u_gain_pga1p5 (
		.i_clk_sys(i_clk_sys),
		.i_nrst(i_nrst),
		.i_wr_en(wr_fire && wr_sel_gain1p5),
		.i_wstrb(wstrb_q[1:0]),
		.i_wdata(wdata_q[COEF_MSB:COEF_LSB]),
		.o_value(gain_pga1p5)
	);

	// Offset coefficient for gain 2, zero after reset.
	cal_coef_reg #(
		.RESET_VALUE(OFFSET_COEF_RESET)
	) u_offset_pga2 (
		.i_clk_sys(i_clk_sys),
		.i_nrst(i_nrst),
		.i_wr_en(wr_fire && wr_sel_off2),
		.i_wstrb(wstrb_q[1:0]),
		.i_wdata(wdata_q[COEF_MSB:COEF_LSB]),
		.o_value(offset_pga2)
	);

	// Offset coefficient for gain 1.5, zero after reset.
	cal_coef_reg #(
		.RESET_VALUE(OFFSET_COEF_RESET)
	) u_offset_pga1p5 (
		.i_clk_sys(i_clk_sys),
		.i_nrst(i_nrst),
		.i_wr_en(wr_fire && wr_sel_off1p5),
		.i_wstrb(wstrb_q[1:0]),
		.i_wdata(wdata_q[COEF_MSB:COEF_LSB]),
		.o_value(offset_pga1p5)
	);

	// Bundle coefficients and the incoming sample for the datapath.
	assign coefs.gain_pga1p5 = gain_pga1p5;
	assign coefs.offset_pga2 = offset_pga2;
	assign coefs.offset_pga1p5 = offset_pga1p5;
	assign raw_sample.valid = i_raw_valid;
	assign raw_sample.gain = i_pga_gain;
	assign raw_sample.excluded = i_excluded_channel;
	assign raw_sample.result = i_conversion_result;

	// The pipeline has two stages. The first picks the offset and gain for the sample's
	// gain setting and subtracts the offset in quarter steps. The second multiplies by the
	// gain, rounds half up and clamps to the unsigned result range. A corrected sample
	// therefore appears exactly two edges after the raw one, one per cycle, with no stall.
	// An illegal zero gain yields a zero result without the saturation flag.
	// Gains other than 1.5 pass with unity gain and, except at gain 2, with no offset;
	// their coefficients live elsewhere.
	// The offset is applied on excluded channels too; only the gain skips them.

	// Correction pipeline.
	cal_datapath u_datapath (
		.i_clk_sys(i_clk_sys),
		.i_nrst(i_nrst),
		.i_sample(raw_sample),
		.i_coefs(coefs),
		.o_sample(cal_sample)
	);

	// The status word lets software see what the pipeline produced without a data path
	// of its own. Bit 16 is the saturation flag of that same sample. The word is read
	// only; a write to it is refused like an unmapped address.
	// Like the two offset registers it resets to zero; the gain coefficient resets to 0x4000.
	// Last corrected result kept for software to read.
	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			last_result_q <= '0;
			last_sat_q <= 1'b0;
		end else if (cal_sample.valid) begin
			last_result_q <= cal_sample.result;
			last_sat_q <= cal_sample.saturated;
		end
	end

	// Every output of this block comes from a flip-flop, so downstream timing sees only
	// clock-to-output delay.
	// The datapath outputs are the second stage registers of the pipeline.
	// Bus outputs straight from their flip-flops.
	assign o_awready = awready_q;
	assign o_wready = wready_q;
	assign o_bvalid = bvalid_q;
	assign o_bresp = bresp_q;
	assign o_arready = arready_q;
	assign o_rvalid = rvalid_q;
	assign o_rdata = rdata_q;
	assign o_rresp = rresp_q;

	// Datapath outputs come from the output stage flip-flops of the pipeline.
	assign o_cal_valid = cal_sample.valid;
	assign o_cal_result = cal_sample.result;
	assign o_cal_saturated = cal_sample.saturated;

endmodule

// file: tb/adc_aux_gain_offset_cal_properties.sv
// Port checker for the calibration stage.
`timescale 1ns/100ps
module adc_aux_gain_offset_cal_properties (
	input wire logic i_clk_sys,
	input wire logic i_nrst,
	input wire logic i_awvalid,
	input wire logic o_awready,
	input wire logic i_wvalid,
	input wire logic o_wready,
	input wire logic o_bvalid,
	input wire logic [1:0] o_bresp,
	input wire logic i_bready,
	input wire logic i_arvalid,
	input wire logic [aux_cal_pkg::AXI_ADDR_W-1:0] i_araddr,
	input wire logic o_arready,
	input wire logic o_rvalid,
	input wire logic [aux_cal_pkg::AXI_DATA_W-1:0] o_rdata,
	input wire logic [1:0] o_rresp,
	input wire logic i_rready,
	input wire logic i_raw_valid,
	input wire logic [aux_cal_pkg::RESULT_W-1:0] i_conversion_result,
	input aux_cal_pkg::pga_gain_e i_pga_gain,
	input wire logic o_cal_valid,
	input wire logic [aux_cal_pkg::RESULT_W-1:0] o_cal_result,
	input wire logic o_cal_saturated
);
	import aux_cal_pkg::*;
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_nrst);
	logic mapped;
	// High when the read address names a register.
	assign mapped = i_araddr inside {ADDR_GAIN_COEF_PGA1P5, ADDR_OFFSET_COEF_PGA2,
		ADDR_OFFSET_COEF_PGA1P5, ADDR_CAL_STATUS};
	sequence s_wr_take;
		i_awvalid && o_awready && i_wvalid && o_wready;
	endsequence
	sequence s_rd_take;
		i_arvalid && o_arready;
	endsequence
	chk_cal_latency: assert property (i_raw_valid |-> ##2 o_cal_valid)
		else $error("corrected sample missing two cycles after raw sample");
	chk_cal_cause: assert property (o_cal_valid |-> $past(i_raw_valid, 2))
		else $error("corrected sample without raw sample");
	chk_unity_pass: assert property (i_raw_valid && i_pga_gain == PGA_GAIN_1 |->
		##2 o_cal_result == $past(i_conversion_result, 2) && !o_cal_saturated)
		else $error("gain one result altered");
	chk_sat_clamp: assert property (o_cal_valid && o_cal_saturated |->
		o_cal_result == 16'hFFFF || o_cal_result == 16'h0000)
		else $error("saturated result not at a limit");
	chk_coef_resv: assert property (s_rd_take ##0 (mapped && i_araddr != ADDR_CAL_STATUS) |=>
		o_rresp == RESP_OKAY && o_rdata[31:15] == 17'h00000)
		else $error("reserved coefficient bits not zero");
	chk_unmapped_rd: assert property (s_rd_take ##0 !mapped |=> o_rresp == RESP_SLVERR && o_rdata == 32'h0)
		else $error("unmapped read not refused");
	chk_read_answer: assert property (s_rd_take |=> o_rvalid && !o_arready)
		else $error("read answer late");
	chk_read_hold: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
		else $error("read data dropped before handshake");
	chk_write_answer: assert property (s_wr_take |=> !o_awready ##[0:1] o_bvalid)
		else $error("write response late");
	chk_bresp_hold: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
		else $error("write response dropped before handshake");
endmodule
bind adc_aux_gain_offset_cal adc_aux_gain_offset_cal_properties u_props (.i_clk_sys, .i_nrst, .i_awvalid,
	.o_awready, .i_wvalid, .o_wready, .o_bvalid, .o_bresp, .i_bready, .i_arvalid, .i_araddr, .o_arready,
	.o_rvalid, .o_rdata, .o_rresp, .i_rready, .i_raw_valid, .i_conversion_result, .i_pga_gain,
	.o_cal_valid, .o_cal_result, .o_cal_saturated);

// file: tb/adc_aux_gain_offset_cal_tb_top.sv
// Self-checking bench of the calibration stage against an integer model.
`timescale 1ns/100ps
module adc_aux_gain_offset_cal_tb_top;
	import aux_cal_pkg::*;
	localparam pga_gain_e GL [5] = '{PGA_GAIN_1, PGA_GAIN_1P5, PGA_GAIN_2, PGA_GAIN_4, PGA_GAIN_9};
	localparam int GV [7] = '{15'h4000, 15'h2000, 15'h7FFF, 15'h4001, 15'h3FFF, 15'h0001, 15'h0000};
	localparam int OV [5] = '{15'h0000, 15'h0001, 15'h7FFF, 15'h3FFF, 15'h4000};
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic raw_valid = 1'b0, excl = 1'b0;
	logic [13:0] awaddr = 14'h0000, araddr = 14'h0000;
	logic [31:0] wdata = 32'h0, rdata;
	logic [3:0] wstrb = 4'h0;
	logic [15:0] raw = 16'h0000, cal_result;
	logic [1:0] bresp, rresp;
	logic awready, wready, bvalid, arready, rvalid, cal_valid, cal_sat;
	pga_gain_e gain = PGA_GAIN_1;
	int n_errors = 0, compares = 0, seed = 17, cyc = 0, g15 = 16384, o15 = 0, o2 = 0;
	logic [16:0] expq [$];
	logic [16:0] last_exp = 17'h00000;
	logic [3:0] strb = 4'hF;
	always #25 clk = ~clk;
	adc_aux_gain_offset_cal dut (.i_clk_sys(clk), .i_nrst(nrst), .i_awvalid(awvalid), .i_awaddr(awaddr),
		.i_awprot(3'h0), .o_awready(awready), .i_wvalid(wvalid), .i_wdata(wdata), .i_wstrb(wstrb),
		.o_wready(wready), .o_bvalid(bvalid), .o_bresp(bresp), .i_bready(bready), .i_arvalid(arvalid),
		.i_araddr(araddr), .i_arprot(3'h0), .o_arready(arready), .o_rvalid(rvalid), .o_rdata(rdata),
		.o_rresp(rresp), .i_rready(rready), .i_raw_valid(raw_valid), .i_conversion_result(raw),
		.i_pga_gain(gain), .i_excluded_channel(excl), .o_cal_valid(cal_valid), .o_cal_result(cal_result),
		.o_cal_saturated(cal_sat));
	// Saturation flag and result: offset in quarter steps, gain with 14 fraction bits.
	function automatic logic [16:0] model(input int r, input int g, input int off);
		longint p;
		p = (longint'(r * 4 - (off >= 16384 ? off - 32768 : off)) * g + 32768) >>> 16;
		if (g == 0) return 17'h00000;
		if (p < 0) return 17'h10000;
		if (p > 65535) return 17'h1FFFF;
		return {1'b0, p[15:0]};
	endfunction
	task report_and_stop();
		$display("errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Write with both channels offered together; bready rises late to stall the response.
	task wr(input logic [13:0] a, input logic [31:0] d, input logic [1:0] er);
		logic aw_done, w_done;
		aw_done = 1'b0;
		w_done = 1'b0;
		awvalid <= 1'b1;
		awaddr <= a;
		wvalid <= 1'b1;
		wdata <= d;
		wstrb <= strb;
		while (!(aw_done && w_done)) begin
			@(posedge clk);
			if (!aw_done && awready) begin
				aw_done = 1'b1;
				awvalid <= 1'b0;
			end
			if (!w_done && wready) begin
				w_done = 1'b1;
				wvalid <= 1'b0;
			end
		end
		repeat (2) @(posedge clk);
		bready <= 1'b1;
		do @(posedge clk); while (!bvalid);
		bready <= 1'b0;
		chk({30'h0, bresp}, {30'h0, er});
	endtask
	// Read with rready held back one cycle after the address is taken.
	task rd(input logic [13:0] a, input logic [31:0] exp, input logic [1:0] er);
		arvalid <= 1'b1;
		araddr <= a;
		do @(posedge clk); while (!arready);
		arvalid <= 1'b0;
		@(posedge clk);
		rready <= 1'b1;
		do @(posedge clk); while (!rvalid);
		rready <= 1'b0;
		chk(rdata, exp);
		chk({30'h0, rresp}, {30'h0, er});
	endtask
	// Back-to-back samples with random code, gain and channel kind; the first two are the code limits.
	task send(input int n);
		logic [15:0] r;
		pga_gain_e gn;
		logic ex;
		for (int i = 0; i < n; i++) begin
			r = (i == 0) ? 16'hFFFF : (i == 1) ? 16'h0000 : 16'($random(seed));
			gn = GL[$unsigned($random(seed)) % 5];
			ex = 1'($random(seed));
			@(posedge clk);
			raw_valid <= 1'b1;
			raw <= r;
			gain <= gn;
			excl <= ex;
			expq.push_back(model(r, (gn == PGA_GAIN_1P5 && !ex) ? g15 : 16384,
				gn == PGA_GAIN_1P5 ? o15 : gn == PGA_GAIN_2 ? o2 : 0));
		end
		@(posedge clk);
		raw_valid <= 1'b0;
		repeat (3) @(posedge clk);
	endtask
	// Each corrected sample is compared with the oldest expectation.
	always @(posedge clk) begin
		if (nrst && cal_valid === 1'b1) begin
			if (expq.size() == 0) chk(32'h1, 32'h0);
			else begin
				last_exp = expq[0];
				chk({15'h0, cal_sat, cal_result}, {15'h0, expq.pop_front()});
			end
		end
	end
	// Hang guard.
	always @(posedge clk) begin
		cyc++;
		if (cyc > 8000) begin
			n_errors++;
			report_and_stop();
		end
	end
	// Main sequence: reset values, refusals, then every gain code with varied offsets.
	initial begin
		repeat (20) @(posedge clk);
		nrst <= 1'b1;
		rd(ADDR_GAIN_COEF_PGA1P5, 32'h00004000, RESP_OKAY);
		rd(ADDR_OFFSET_COEF_PGA2, 32'h00000000, RESP_OKAY);
		rd(ADDR_OFFSET_COEF_PGA1P5, 32'h00000000, RESP_OKAY);
		rd(14'h0004, 32'h00000000, RESP_SLVERR);
		wr(14'h0004, 32'h00000001, RESP_SLVERR);
		rd(ADDR_CAL_STATUS, 32'h00000000, RESP_OKAY);
		wr(ADDR_CAL_STATUS, 32'h00000001, RESP_SLVERR);
		send(12);
		for (int k = 0; k < 7; k++) begin
			g15 = GV[k];
			o15 = OV[k % 5];
			o2 = OV[(k + 2) % 5];
			wr(ADDR_GAIN_COEF_PGA1P5, {17'h1FFFF, g15[14:0]}, RESP_OKAY);
			wr(ADDR_OFFSET_COEF_PGA2, {17'h1FFFF, o2[14:0]}, RESP_OKAY);
			wr(ADDR_OFFSET_COEF_PGA1P5, {17'h1FFFF, o15[14:0]}, RESP_OKAY);
			rd(ADDR_GAIN_COEF_PGA1P5, {17'h0, g15[14:0]}, RESP_OKAY);
			rd(ADDR_OFFSET_COEF_PGA2, {17'h0, o2[14:0]}, RESP_OKAY);
			send(24);
			rd(ADDR_CAL_STATUS, {15'h0, last_exp}, RESP_OKAY);
		end
		strb = 4'h1;
		wr(ADDR_OFFSET_COEF_PGA2, 32'h00007F55, RESP_OKAY);
		strb = 4'hF;
		rd(ADDR_OFFSET_COEF_PGA2, {17'h0, o2[14:8], 8'h55}, RESP_OKAY);
		chk(32'(expq.size()), 32'h0);
		report_and_stop();
	end
endmodule
